// >>> design/regulator_cfg_pkg.sv
// Constants, field layouts and carrier types for the regulator
// sleep, voltage select and discharge configuration block.
// Assumes a Wishbone slave with 32-bit data and word-aligned registers.
package regulator_cfg_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_DEFAULT_VOLTAGE = 8'h2B;
   localparam logic [7:0] IDX_SELECT_PIN_MAPPING = 8'h2C;
   localparam logic [7:0] IDX_LDO_DISCHARGE = 8'h2D;
   localparam logic [7:0] IDX_CONVERTER_DISCHARGE = 8'h2E;
   localparam logic [7:0] IDX_KEEP_ACTIVE = 8'h40;
   localparam logic [7:0] IDX_FORCE_OFF = 8'h41;
   localparam logic [7:0] IDX_SLEEP_STATUS = 8'h42;

   // ----------------------------------------------------------------
   // Field layouts
   // ----------------------------------------------------------------
   localparam int MAP_FIELD_W = 2;
   localparam int MAPPED_LDOS = 4;
   localparam int LDO_COUNT = 8;
   localparam int CONVERTER_COUNT = 4;
   localparam int LDO_DEFV_LSB = 4;
   localparam int CONV_DISCHARGE_W = 6;
   localparam int STRAP_GATED_LDO = 3;
   localparam int SYNC_STAGES = 2;

   // Reset value of reserved bits, the converter discharge bits 7:6
   localparam logic [7:0] RESERVED_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Sleep outcome of one regulator
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SLEEP_LOW_POWER = 2'b00,
      SLEEP_ACTIVE = 2'b01,
      SLEEP_OFF = 2'b10
   } sleep_outcome_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   // Factory-programmed defaults loaded at power-on reset
   typedef struct packed {
      logic [7:0] keep_active;
      logic [7:0] force_off;
      logic [7:0] default_voltage;
      logic [7:0] pin_map;
      logic [7:0] ldo_discharge;
      logic [5:0] converter_discharge;
   } otp_defaults_t;

   // Per-regulator controls towards the analog side, LDO1 in bit 0
   typedef struct packed {
      logic [7:0] active;
      logic [7:0] low_power;
      logic [7:0] off;
      logic [7:0] use_alternate;
      logic [7:0] ldo_discharge;
      logic [5:0] converter_discharge;
   } regulator_ctrl_t;

endpackage

// >>> design/regulator_sleep_voltage_discharge_ctrl.sv
// Register bank that resolves each linear regulator's sleep outcome,
// its normal/alternate voltage choice and its discharge-on-disable enable.
// Assumes a classic Wishbone master, converter select pins and the strap
// level asynchronous inputs, and factory defaults held stable at reset.
// Regulators 5 to 8 have no pin mapping and no alternate setting.
// Writes use byte lane 0 only; the status word reads back on lanes 0 to 2.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/10ps

module regulator_sleep_voltage_discharge_ctrl
   import regulator_cfg_pkg::*;
#(
   parameter int SEL_PINS = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Device side
   input wire logic sleep_i,
   input wire logic [SEL_PINS-1:0] converter_voltage_select_pin_i,
   input wire logic config_strap_two_i,
   input wire otp_defaults_t otp_defaults_i,
   output regulator_ctrl_t regulator_ctrl_o
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Word index of the current bus request
   function automatic logic [7:0] word_index(input logic [9:0] adr);
      word_index = adr[9:2];
   endfunction

   // Resolve the sleep outcome from keep-active and force-off
   function automatic sleep_outcome_t resolve_sleep(input logic keep, input logic force_off);
      if (keep) begin
         resolve_sleep = SLEEP_ACTIVE;
      end else if (force_off) begin
         resolve_sleep = SLEEP_OFF;
      end else begin
         resolve_sleep = SLEEP_LOW_POWER;
      end
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0] default_voltage_r;
   logic [7:0] pin_map_r;
   logic [7:0] ldo_discharge_r;
   logic [5:0] converter_discharge_r;
   logic [7:0] keep_active_r;
   logic [7:0] force_off_r;
   logic strap_two_r;
   logic [SEL_PINS-1:0] sel_meta_r;
   logic [SEL_PINS-1:0] sel_sync_r;
   logic [MAPPED_LDOS-1:0] applied_r;
   logic [MAPPED_LDOS-1:0] chosen_level;
   logic [MAPPED_LDOS-1:0] follow_en;
   logic [MAPPED_LDOS-1:0] pin_change;
   logic ack_r;
   logic [31:0] rd_data_r;
   logic [31:0] rd_data_nxt;
   logic bus_req;
   logic wr_byte0;
   logic [7:0] req_index;
   logic [7:0] wr_data;
   logic [7:0] sleep_active;
   logic [7:0] sleep_low_power;
   logic [7:0] sleep_off;
   logic [7:0] active_r;
   logic [7:0] low_power_r;
   logic [7:0] off_r;
   logic [7:0] use_alternate_r;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // A request is taken on the edge where no answer is pending
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
   assign req_index = word_index(wb_adr_i);
   // Writes with lane 0 disabled are ignored
   assign wr_byte0 = bus_req && wb_we_i && wb_sel_i[0];
   assign wr_data = wb_dat_i[7:0];

   // ----------------------------------------------------------------
   // Select pin synchronisation
   // ----------------------------------------------------------------
   // Two stages before any logic looks at the pins
   // No reset: the stages keep sampling while reset is held, so the first
   // compare after release sees the true pin level and no false change
   always_ff @(posedge clk_i) begin
      sel_meta_r <= converter_voltage_select_pin_i;
      sel_sync_r <= sel_meta_r;
   end

   // Strap level caught while reset is held
   // Held after release; a new strap level needs a new power-on reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_two_r <= config_strap_two_i;
      end
   end

   // ----------------------------------------------------------------
   // Pin-to-regulator mapping for LDO1..LDO4
   // ----------------------------------------------------------------
   // Each two-bit field picks one converter pin
   genvar g;
   generate
      for (g = 0; g < MAPPED_LDOS; g++) begin : g_map
         // Field g sits at bits 2g+1..2g
         assign chosen_level[g] = sel_sync_r[pin_map_r[g*MAP_FIELD_W +: MAP_FIELD_W]];
         if (g == STRAP_GATED_LDO) begin : g_strap
            assign follow_en[g] = !strap_two_r;
         end else begin : g_free
            assign follow_en[g] = 1'b1;
         end
         // A new level differing from the one last applied
         assign pin_change[g] = follow_en[g] && (chosen_level[g] != applied_r[g]);
      end
   endgenerate

   // Level last copied into each mapped default-voltage bit
   // Loaded with the factory bits, so a pin already at that level
   // causes no change at release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         applied_r <= otp_defaults_i.default_voltage[LDO_DEFV_LSB +: MAPPED_LDOS];
      end else begin
         applied_r <= applied_r ^ pin_change;
      end
   end

   // ----------------------------------------------------------------
   // Default-voltage register
   // ----------------------------------------------------------------
   // Software writes; a pin change in the same cycle wins for its bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         default_voltage_r <= otp_defaults_i.default_voltage;
      end else begin
         // Converter bits 3:0 are plain read/write
         if (wr_byte0 && req_index == IDX_DEFAULT_VOLTAGE) begin
            default_voltage_r <= wr_data;
         end
         // Pin changes come last so they win over a same-cycle write
         for (int j = 0; j < MAPPED_LDOS; j++) begin
            if (pin_change[j]) begin
               default_voltage_r[LDO_DEFV_LSB + j] <= chosen_level[j];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Mapping and discharge registers
   // ----------------------------------------------------------------
   // Pin-map fields; factory values reload on every power-on reset
   // A remap acts at once; a new pin of other level then gets applied
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_map_r <= otp_defaults_i.pin_map;
      end else if (wr_byte0 && req_index == IDX_SELECT_PIN_MAPPING) begin
         pin_map_r <= wr_data;
      end
   end

   // Discharge-on-disable enables of LDO1..LDO8
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ldo_discharge_r <= otp_defaults_i.ldo_discharge;
      end else if (wr_byte0 && req_index == IDX_LDO_DISCHARGE) begin
         ldo_discharge_r <= wr_data;
      end
   end

   // Converter discharge enables; bits 7:6 are not stored
   // and read back as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         converter_discharge_r <= otp_defaults_i.converter_discharge;
      end else if (wr_byte0 && req_index == IDX_CONVERTER_DISCHARGE) begin
         converter_discharge_r <= wr_data[CONV_DISCHARGE_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Sleep configuration registers
   // ----------------------------------------------------------------
   // Keep-active bits, LDO1 in bit 0
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         keep_active_r <= otp_defaults_i.keep_active;
      end else if (wr_byte0 && req_index == IDX_KEEP_ACTIVE) begin
         keep_active_r <= wr_data;
      end
   end

   // Force-off bits, LDO1 in bit 0
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         force_off_r <= otp_defaults_i.force_off;
      end else if (wr_byte0 && req_index == IDX_FORCE_OFF) begin
         force_off_r <= wr_data;
      end
   end

   // ----------------------------------------------------------------
   // Sleep outcome per regulator
   // ----------------------------------------------------------------
   // Outside sleep every regulator stays active
   // Low power is the fallback, so no stray code ever reads as off
   always_comb begin
      sleep_outcome_t outcome;
      outcome = SLEEP_ACTIVE;
      sleep_active = '0;
      sleep_low_power = '0;
      sleep_off = '0;
      for (int i = 0; i < LDO_COUNT; i++) begin
         outcome = sleep_i ? resolve_sleep(keep_active_r[i], force_off_r[i]) : SLEEP_ACTIVE;
         case (outcome)
            SLEEP_ACTIVE: begin
               sleep_active[i] = 1'b1;
            end
            SLEEP_OFF: begin
               sleep_off[i] = 1'b1;
            end
            default: begin
               sleep_low_power[i] = 1'b1;
            end
         endcase
      end
   end

   // Registered controls towards the regulators
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_r <= '1;
         low_power_r <= '0;
         off_r <= '0;
         use_alternate_r <= '0;
      end else begin
         active_r <= sleep_active;
         low_power_r <= sleep_low_power;
         off_r <= sleep_off;
         // Alternate setting for LDO1..4 whatever the sleep outcome
         // Bits 7:4 stay zero, LDO5..8 have no alternate setting
         use_alternate_r <= {4'h0, default_voltage_r[LDO_DEFV_LSB +: MAPPED_LDOS]};
      end
   end

   // ----------------------------------------------------------------
   // Outputs towards the analog side
   // ----------------------------------------------------------------
   // Sleep masks and voltage choice come from flops,
   // discharge enables straight from their registers
   assign regulator_ctrl_o.active = active_r;
   assign regulator_ctrl_o.low_power = low_power_r;
   assign regulator_ctrl_o.off = off_r;
   assign regulator_ctrl_o.use_alternate = use_alternate_r;
   assign regulator_ctrl_o.ldo_discharge = ldo_discharge_r;
   assign regulator_ctrl_o.converter_discharge = converter_discharge_r;

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // Unmapped indices and reserved bits read as zero
   always_comb begin
      rd_data_nxt = '0;
      case (req_index)
         IDX_DEFAULT_VOLTAGE: begin
            rd_data_nxt[7:0] = default_voltage_r;
         end
         IDX_SELECT_PIN_MAPPING: begin
            rd_data_nxt[7:0] = pin_map_r;
         end
         IDX_LDO_DISCHARGE: begin
            rd_data_nxt[7:0] = ldo_discharge_r;
         end
         IDX_CONVERTER_DISCHARGE: begin
            rd_data_nxt[7:0] = {RESERVED_RESET[1:0], converter_discharge_r};
         end
         IDX_KEEP_ACTIVE: begin
            rd_data_nxt[7:0] = keep_active_r;
         end
         IDX_FORCE_OFF: begin
            rd_data_nxt[7:0] = force_off_r;
         end
         // Status word: active and off masks, synced pins and captured strap
         IDX_SLEEP_STATUS: begin
            rd_data_nxt[7:0] = active_r;
            rd_data_nxt[15:8] = off_r;
            rd_data_nxt[19:16] = sel_sync_r[3:0];
            rd_data_nxt[20] = strap_two_r;
         end
         default: begin
            rd_data_nxt = '0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Wishbone answer
   // ----------------------------------------------------------------
   // Ack one cycle after the request, dropped the cycle after
   // Read data is caught at the take edge and stands until the next read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rd_data_r <= '0;
      end else begin
         ack_r <= bus_req;
         if (bus_req && !wb_we_i) begin
            rd_data_r <= rd_data_nxt;
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rd_data_r;

endmodule

// >>> verif/host_sel_model.sv
// Host-side model driving the converter select pins.
// Assumes the bench names the wanted level and a lag in cycles.
`timescale 1ns/10ps
module host_sel_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] want_i,
   input wire logic [3:0] lag_i,
   output logic [3:0] pins_o
);
   logic [3:0] cnt_r;
   // Pins take the wanted level lag_i+1 cycles after it changes, promptly or slowly
   always_ff @(posedge clk_i) begin
      if (rst_i || want_i == pins_o) begin
         cnt_r <= 4'h0;
         if (rst_i) pins_o <= 4'h0;
      end else if (cnt_r >= lag_i) begin
         pins_o <= want_i;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule

// >>> verif/reg_cfg_chk.sv
// Port assertions for the regulator configuration block.
// Assumes it is bound to the block; one clock, synchronous reset.
`timescale 1ns/10ps
module reg_cfg_chk
   import regulator_cfg_pkg::*;
#(
   parameter int SEL_PINS = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic sleep_i,
   input wire logic [SEL_PINS-1:0] converter_voltage_select_pin_i,
   input wire logic config_strap_two_i,
   input wire otp_defaults_t otp_defaults_i,
   input wire regulator_ctrl_t regulator_ctrl_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Taken request, and a taken low-byte write to one index
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_wr(idx);
      s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == idx);
   endsequence
   // Bus answer timing and read width
   a_ack_after_take: assert property (s_take |=> wb_ack_o)
      else $error("ack missing");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_read_upper_zero: assert property (wb_ack_o && !$past(wb_we_i)
      && $past(wb_adr_i[9:2]) != IDX_SLEEP_STATUS |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read upper bits set");
   // Register loads and writes
   a_reset_load: assert property ($fell(rst_i) |->
      regulator_ctrl_o.ldo_discharge == otp_defaults_i.ldo_discharge &&
      regulator_ctrl_o.converter_discharge == otp_defaults_i.converter_discharge)
      else $error("discharge not loaded at reset");
   a_ldo_dis_write: assert property (s_wr(IDX_LDO_DISCHARGE) |=>
      regulator_ctrl_o.ldo_discharge == $past(wb_dat_i[7:0]))
      else $error("ldo discharge write lost");
   a_conv_dis_write: assert property (s_wr(IDX_CONVERTER_DISCHARGE) |=>
      regulator_ctrl_o.converter_discharge == $past(wb_dat_i[5:0]))
      else $error("converter discharge write lost");
   // Sleep outcome and voltage choice
   a_awake_active: assert property (!sleep_i |=> regulator_ctrl_o.active == 8'hFF)
      else $error("awake regulator not active");
   a_outcome_excl: assert property (
      (regulator_ctrl_o.active | regulator_ctrl_o.low_power | regulator_ctrl_o.off) == 8'hFF
      && (regulator_ctrl_o.active & regulator_ctrl_o.low_power) == 8'h00
      && ((regulator_ctrl_o.active | regulator_ctrl_o.low_power) & regulator_ctrl_o.off) == 8'h00)
      else $error("sleep outcome not exclusive");
   a_alt_upper_zero: assert property (regulator_ctrl_o.use_alternate[7:4] == 4'h0)
      else $error("unmapped alternate set");
endmodule

// >>> verif/test_regulator_sleep_voltage_discharge_ctrl.sv
// Self-checking bench for the regulator configuration block.
// Assumes the package, the block, its checker and the host pin model.
`timescale 1ns/10ps
module test_regulator_sleep_voltage_discharge_ctrl;
   import regulator_cfg_pkg::*;
   logic clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, slp = 1'h0;
   logic strap = 1'h0;
   logic [3:0] sel = 4'hF;
   logic [9:0] adr = 10'h000;
   logic [31:0] wdat = 32'h0, rdat;
   logic [3:0] want = 4'h0, lag = 4'h0, pins;
   logic [7:0] v, ka, fo, q;
   logic [23:0] e;
   otp_defaults_t otp = '0;
   regulator_ctrl_t ctrl;
   integer seed = 55330;
   int miscompares = 0, total_checks = 0;

   always #12.5 clk = ~clk;

   regulator_sleep_voltage_discharge_ctrl #(.SEL_PINS(4)) u_dut (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .sleep_i(slp), .converter_voltage_select_pin_i(pins), .config_strap_two_i(strap),
      .otp_defaults_i(otp), .regulator_ctrl_o(ctrl));
   host_sel_model u_host (.clk_i(clk), .rst_i(rst), .want_i(want), .lag_i(lag), .pins_o(pins));

   // ----------------------------------------
   // Tasks and expectations
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] x, input logic [31:0] g);
      total_checks++;
      if (g !== x) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, x, g);
      end
   endtask
   // One classic bus cycle; q takes read data at the ack edge
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= {idx, 2'h0};
      wdat <= {24'h0, d};
      // Waits until ack is seen; only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge clk);
      end while (ack !== 1'h1);
      q = rdat[7:0];
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [7:0] x, input string what);
      wb(1'h0, idx, 8'h00);
      check(what, 32'(x), 32'(q));
   endtask
   task automatic do_reset(input logic s);
      rst <= 1'h1;
      strap <= s;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Active, low-power and off masks of the eight regulators
   function automatic logic [23:0] f_outcome(logic s, logic [7:0] k, logic [7:0] f);
      if (!s) return {8'hFF, 16'h0000};
      return {k, ~k & ~f, ~k & f};
   endfunction
   // Level of the pin that a map value chooses for one regulator
   function automatic logic f_sel(logic [7:0] m, int l, logic [3:0] p);
      return p[m[2*l +: 2]];
   endfunction

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      give_verdict;
   end

   initial begin
      otp <= 46'({$random(seed), $random(seed)});
      do_reset(1'h0);
      rdchk(IDX_SELECT_PIN_MAPPING, otp.pin_map, "map reset");
      rdchk(IDX_LDO_DISCHARGE, otp.ldo_discharge, "ldo dis reset");
      rdchk(IDX_CONVERTER_DISCHARGE, {2'h0, otp.converter_discharge}, "conv reset");
      wb(1'h1, 8'h10, 8'hFF);
      rdchk(8'h10, 8'h00, "unmapped");
      $display("test reset values done");
      repeat (6) begin
         v = 8'($random(seed));
         wb(1'h1, IDX_LDO_DISCHARGE, v);
         wb(1'h1, IDX_CONVERTER_DISCHARGE, v);
         wb(1'h1, IDX_SELECT_PIN_MAPPING, v);
         rdchk(IDX_LDO_DISCHARGE, v, "ldo dis");
         check("ldo dis out", 32'(v), 32'(ctrl.ldo_discharge));
         rdchk(IDX_CONVERTER_DISCHARGE, {2'h0, v[5:0]}, "conv dis");
         rdchk(IDX_SELECT_PIN_MAPPING, v, "map");
         check("conv dis out", 32'(v[5:0]), 32'(ctrl.converter_discharge));
         sel <= 4'hE;
         wb(1'h1, IDX_LDO_DISCHARGE, ~v);
         sel <= 4'hF;
         rdchk(IDX_LDO_DISCHARGE, v, "lane off");
      end
      $display("test register access done");
      for (int l = 0; l < 4; l++) begin
         for (int c = 0; c < 4; c++) begin
            v = 8'(c << (2 * l));
            wb(1'h1, IDX_SELECT_PIN_MAPPING, v);
            wb(1'h1, IDX_DEFAULT_VOLTAGE, 8'h00);
            lag <= 4'($random(seed) & 3);
            want <= 4'(1 << c);
            repeat (12) @(posedge clk);
            check("pin on", 32'(f_sel(v, l, want)), 32'(ctrl.use_alternate[l]));
            want <= 4'h0;
            repeat (12) @(posedge clk);
            check("pin off", 32'h0, 32'(ctrl.use_alternate[l]));
         end
      end
      $display("test pin mapping done");
      do_reset(1'h1);
      wb(1'h1, IDX_SELECT_PIN_MAPPING, 8'hC0);
      wb(1'h1, IDX_DEFAULT_VOLTAGE, 8'h00);
      want <= 4'h8;
      repeat (12) @(posedge clk);
      check("strap high", 32'h0, 32'(ctrl.use_alternate[3]));
      want <= 4'h0;
      do_reset(1'h0);
      rdchk(IDX_SELECT_PIN_MAPPING, otp.pin_map, "map reload");
      rdchk(IDX_LDO_DISCHARGE, otp.ldo_discharge, "ldo dis reload");
      $display("test strap done");
      repeat (4) begin
         v = 8'($random(seed));
         wb(1'h1, IDX_DEFAULT_VOLTAGE, v);
         rdchk(IDX_DEFAULT_VOLTAGE, v, "default_voltage_bits");
         check("alt select", 32'(v[7:4]), 32'(ctrl.use_alternate));
      end
      $display("test voltage select done");
      for (int i = 0; i < 8; i++) begin
         ka = (i == 0) ? 8'h0F : 8'($random(seed));
         fo = (i == 0) ? 8'h33 : 8'($random(seed));
         wb(1'h1, IDX_KEEP_ACTIVE, ka);
         wb(1'h1, IDX_FORCE_OFF, fo);
         slp <= (i == 0) ? 1'h1 : 1'($random(seed));
         repeat (2) @(posedge clk);
         e = f_outcome(slp, ka, fo);
         check("sleep", 32'(e), 32'({ctrl.active, ctrl.low_power, ctrl.off}));
         rdchk(IDX_SLEEP_STATUS, e[23:16], "status");
      end
      $display("test sleep outcome done");
      give_verdict;
   end
endmodule

bind regulator_sleep_voltage_discharge_ctrl reg_cfg_chk #(.SEL_PINS(SEL_PINS)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_i(sleep_i),
   .converter_voltage_select_pin_i(converter_voltage_select_pin_i),
   .config_strap_two_i(config_strap_two_i), .otp_defaults_i(otp_defaults_i),
   .regulator_ctrl_o(regulator_ctrl_o));
